// ---- hw/lsb_defines.vh ----
// Constants for the logic signal bank: register map, fields, timing.
// Assumes a 20 MHz clock and a 32-bit classic Wishbone slave port.
`ifndef LSB_DEFINES_VH
`define LSB_DEFINES_VH

// Register byte offsets
`define LSB_ADDR_OUT_STATE   8'h00
`define LSB_ADDR_IN_STATE    8'h04
`define LSB_ADDR_IN_MODE     8'h08
`define LSB_ADDR_CMD_SET     8'h0c
`define LSB_ADDR_CMD_CLR     8'h10
`define LSB_ADDR_EV_ENABLE   8'h14
`define LSB_ADDR_EV_FIFO     8'h18
`define LSB_ADDR_EV_STAMP    8'h1c
`define LSB_ADDR_IRQ_STATUS  8'h20
`define LSB_ADDR_IRQ_MASK    8'h24
`define LSB_ADDR_TIME        8'h28

// Event enable bits
`define LSB_EN_OUT_ON        0
`define LSB_EN_OUT_OFF       1
`define LSB_EN_IN_ON         2
`define LSB_EN_IN_OFF        3
`define LSB_EN_RESET         4'h0

// Event word fields
`define LSB_EV_VALID         31
`define LSB_EV_BLOCK         8
`define LSB_EV_ON            5

// Interrupt status bits
`define LSB_IRQ_EVENT        0
`define LSB_IRQ_OVERFLOW     1

// Timing
`define LSB_CLK_HZ           20000000
`define LSB_PULSE_US         5000
`define LSB_MS_US            1000
`define LSB_PULSE_MS         3'h5
`define LSB_MS_CYCLES        ((`LSB_CLK_HZ / 1000) * `LSB_MS_US / 1000)

`endif

// ---- hw/lsb_event_sel.v ----
// Picks the lowest pending change among 64 signals and encodes it as an event.
// Assumes the caller holds pending bits until this picks them.
`timescale 1ns/1ps
`default_nettype none
`include "lsb_defines.vh"

module lsb_event_sel
(
    // Pending changes and current levels
    input  wire [63:0] pend,
    input  wire [63:0] level,
    // Selection
    output reg         found,
    output reg  [5:0]  index,
    output reg         on
);

    integer i;

    always @*
    begin
        found = 1'b0;
        index = 6'h00;
        for (i = 63; i >= 0; i = i - 1)
        begin
            if (pend[i])
            begin
                found = 1'b1;
                index = i[5:0];
            end
        end
        on = level[index];
    end

endmodule // lsb_event_sel

`default_nettype wire

// ---- hw/lsb_bank.v ----
// Logic signal bank: 32 command-driven inputs, 32 user-logic outputs, event log.
// Assumes classic Wishbone, one 20 MHz clock, synchronous active-high reset.
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "lsb_defines.vh"

module lsb_bank
#(
    parameter N         = 32,
    parameter EV_DEPTH  = 16,
    parameter EV_AW     = 4,
    parameter MS_CYCLES = `LSB_MS_CYCLES
)
(
    // Clock and reset
    input  wire          clk,
    input  wire          sys_rst,
    // Wishbone slave
    input  wire          wb_cyc_i,
    input  wire          wb_stb_i,
    input  wire          wb_we_i,
    input  wire [7:0]    wb_adr_i,
    input  wire [3:0]    wb_sel_i,
    input  wire [31:0]   wb_dat_i,
    output reg  [31:0]   wb_dat_o,
    output reg           wb_ack_o,
    // Local virtual switch commands
    input  wire [N-1:0]  sw_set,
    input  wire [N-1:0]  sw_clr,
    // User logic
    input  wire [N-1:0]  user_output_logic,
    output reg  [N-1:0]  user_input_signal,
    output reg  [N-1:0]  user_output_signal,
    // Interrupt
    output wire          irq
);

    //==========================================================
    // Declarations
    //==========================================================
    reg  [31:0]       time_ms_q;
    reg  [15:0]       div_q;
    reg  [N-1:0]      mode_q;
    reg  [23:0]       pcnt_q [0:N-1];
    reg  [N-1:0]      in_prev_q;
    reg  [N-1:0]      out_prev_q;
    reg  [63:0]       pend_q;
    reg  [3:0]        en_q;
    reg  [31:0]       ev_word  [0:EV_DEPTH-1];
    reg  [31:0]       ev_stamp [0:EV_DEPTH-1];
    reg  [EV_AW-1:0]  wp_q;
    reg  [EV_AW-1:0]  rp_q;
    reg  [EV_AW:0]    cnt_q;
    reg  [31:0]       stamp_hold_q;
    reg  [1:0]        ist_q;
    reg  [1:0]        imask_q;
    wire              req;
    wire              wr;
    wire              rd;
    wire [N-1:0]      cmd_set;
    wire [N-1:0]      cmd_clr;
    wire [63:0]       level;
    wire [63:0]       chg;
    wire              found;
    wire [5:0]        sel_idx;
    wire              sel_on;
    wire              keep;
    wire              full;
    wire              empty;
    wire              pop;
    wire              push;
    wire              ev_set;
    wire              ov_set;
    integer           k;

    // Pulse length in clocks, counted per input so every pulse is exact
    localparam PULSE_CYC = `LSB_PULSE_MS * MS_CYCLES;

    function [31:0] lane_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  sel;
        integer b;
        begin
            lane_merge = old;
            for (b = 0; b < 4; b = b + 1)
                if (sel[b])
                    lane_merge[b*8 +: 8] = nw[b*8 +: 8];
        end
    endfunction

    //==========================================================
    // Bus decode
    //==========================================================
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr  = req & wb_we_i;
    assign rd  = req & ~wb_we_i;

    assign cmd_set = sw_set | ((wr && wb_adr_i == `LSB_ADDR_CMD_SET)
                     ? lane_merge(32'h0, wb_dat_i, wb_sel_i) : {N{1'b0}});
    assign cmd_clr = sw_clr | ((wr && wb_adr_i == `LSB_ADDR_CMD_CLR)
                     ? lane_merge(32'h0, wb_dat_i, wb_sel_i) : {N{1'b0}});

    always @(posedge clk)
    begin
        if (sys_rst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req;
    end

    //==========================================================
    // Millisecond time base
    //==========================================================
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            div_q     <= 16'h0000;
            time_ms_q <= 32'h0;
        end
        else
        begin
            if (div_q == MS_CYCLES[15:0] - 16'h0001)
            begin
                div_q     <= 16'h0000;
                time_ms_q <= time_ms_q + 32'h1;
            end
            else
                div_q <= div_q + 16'h0001;
        end
    end

    //==========================================================
    // Input bank
    //==========================================================
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            user_input_signal <= {N{1'b0}};
            mode_q            <= {N{1'b0}};
            for (k = 0; k < N; k = k + 1)
                pcnt_q[k] <= 24'h0;
        end
        else
        begin
            if (wr && wb_adr_i == `LSB_ADDR_IN_MODE)
                mode_q <= lane_merge(mode_q, wb_dat_i, wb_sel_i);
            for (k = 0; k < N; k = k + 1)
            begin
                if (!mode_q[k])
                begin
                    pcnt_q[k] <= 24'h0;
                    if (cmd_set[k])
                        user_input_signal[k] <= 1'b1;
                    else if (cmd_clr[k])
                        user_input_signal[k] <= 1'b0;
                end
                else if (pcnt_q[k] != 24'h0)
                begin
                    // Running pulse ignores both commands
                    if (pcnt_q[k] == 24'h1)
                    begin
                        pcnt_q[k]            <= 24'h0;
                        user_input_signal[k] <= 1'b0;
                    end
                    else
                        pcnt_q[k] <= pcnt_q[k] - 24'h1;
                end
                else if (cmd_set[k])
                begin
                    // Counter runs on clocks, not on the shared ms tick
                    pcnt_q[k]            <= PULSE_CYC[23:0];
                    user_input_signal[k] <= 1'b1;
                end
                else
                    user_input_signal[k] <= 1'b0;
            end
        end
    end

    //==========================================================
    // Output bank
    //==========================================================
    always @(posedge clk)
    begin
        if (sys_rst)
            user_output_signal <= {N{1'b0}};
        else
            user_output_signal <= user_output_logic;
    end

    //==========================================================
    // Change detection and event selection
    //==========================================================
    assign level = {user_input_signal, user_output_signal};
    assign chg   = level ^ {in_prev_q, out_prev_q};

    lsb_event_sel u_sel
    (
        .pend  (pend_q),
        .level (level),
        .found (found),
        .index (sel_idx),
        .on    (sel_on)
    );

    assign keep  = sel_idx[5] ? (sel_on ? en_q[`LSB_EN_IN_ON] : en_q[`LSB_EN_IN_OFF])
                              : (sel_on ? en_q[`LSB_EN_OUT_ON] : en_q[`LSB_EN_OUT_OFF]);
    assign full  = (cnt_q == EV_DEPTH);
    assign empty = (cnt_q == 0);
    assign pop   = rd && wb_adr_i == `LSB_ADDR_EV_FIFO && !empty;
    assign push  = found && keep && !full;
    assign ev_set = push;
    assign ov_set = found && keep && full;

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            in_prev_q  <= {N{1'b0}};
            out_prev_q <= {N{1'b0}};
            pend_q     <= 64'h0;
            en_q       <= `LSB_EN_RESET;
        end
        else
        begin
            in_prev_q  <= user_input_signal;
            out_prev_q <= user_output_signal;
            // Pending set wins over the clear of the picked entry
            pend_q <= (pend_q & ~({63'h0, found} << sel_idx)) | chg;
            if (wr && wb_adr_i == `LSB_ADDR_EV_ENABLE && wb_sel_i[0])
                en_q <= wb_dat_i[3:0];
        end
    end

    //==========================================================
    // Event buffer with time stamps
    //==========================================================
    always @(posedge clk)
    begin
        if (push)
        begin
            ev_word[wp_q] <= {1'b1, 22'h0, sel_idx[5], 2'h0, sel_on, sel_idx[4:0]};
            ev_stamp[wp_q] <= time_ms_q;
        end
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            wp_q         <= {EV_AW{1'b0}};
            rp_q         <= {EV_AW{1'b0}};
            cnt_q        <= {(EV_AW+1){1'b0}};
            stamp_hold_q <= 32'h0;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
            begin
                rp_q         <= rp_q + 1'b1;
                stamp_hold_q <= ev_stamp[rp_q];
            end
            cnt_q <= cnt_q + {{EV_AW{1'b0}}, push} - {{EV_AW{1'b0}}, pop};
        end
    end

    //==========================================================
    // Interrupts
    //==========================================================
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            ist_q   <= 2'h0;
            imask_q <= 2'h0;
        end
        else
        begin
            if (rd && wb_adr_i == `LSB_ADDR_IRQ_STATUS)
                ist_q <= {ov_set, ev_set};
            else
                ist_q <= ist_q | {ov_set, ev_set};
            if (wr && wb_adr_i == `LSB_ADDR_IRQ_MASK && wb_sel_i[0])
                imask_q <= wb_dat_i[1:0];
        end
    end

    assign irq = |(ist_q & imask_q);

    //==========================================================
    // Read data
    //==========================================================
    always @(posedge clk)
    begin
        if (sys_rst)
            wb_dat_o <= 32'h0;
        else if (rd)
        begin
            case (wb_adr_i)
                `LSB_ADDR_OUT_STATE:  wb_dat_o <= user_output_signal;
                `LSB_ADDR_IN_STATE:   wb_dat_o <= user_input_signal;
                `LSB_ADDR_IN_MODE:    wb_dat_o <= mode_q;
                `LSB_ADDR_EV_ENABLE:  wb_dat_o <= {28'h0, en_q};
                `LSB_ADDR_EV_FIFO:    wb_dat_o <= empty ? 32'h0 : ev_word[rp_q];
                `LSB_ADDR_EV_STAMP:   wb_dat_o <= stamp_hold_q;
                `LSB_ADDR_IRQ_STATUS: wb_dat_o <= {30'h0, ist_q};
                `LSB_ADDR_IRQ_MASK:   wb_dat_o <= {30'h0, imask_q};
                `LSB_ADDR_TIME:       wb_dat_o <= time_ms_q;
                default:              wb_dat_o <= 32'h0;
            endcase
        end
    end

endmodule // lsb_bank

`default_nettype wire

// ---- sim/lsb_user_logic.sv ----
// User logic model on the far side of the bank.
// Assumes one clock; bench supplies the other output bits.
`timescale 1ns/1ps
`default_nettype none
module lsb_user_logic
#(
    parameter DLY = 40
)
(
    // Clock
    input  wire logic        clk,
    // Bank side
    input  wire logic [31:0] user_input_signal,
    input  wire logic [31:0] pattern,
    output logic      [31:0] user_output_logic
);
    // ==========
    // Off-delay stretch of input 0 onto output 0
    int cnt = 0;
    always @(posedge clk)
        cnt <= user_input_signal[0] ? DLY : (cnt > 0 ? cnt - 1 : 0);
    assign user_output_logic = {pattern[31:1], cnt > 0};
endmodule // lsb_user_logic
`default_nettype wire

// ---- sim/lsb_bank_checker.sv ----
// Port assertions for the logic signal bank.
// Bound to lsb_bank; expects the map in lsb_defines.vh.
`timescale 1ns/1ps
`default_nettype none
`include "lsb_defines.vh"
module lsb_bank_checker
#(
    parameter N = 32
)
(
    // Clock and reset
    input wire logic         clk,
    input wire logic         sys_rst,
    // Wishbone
    input wire logic         wb_cyc_i,
    input wire logic         wb_stb_i,
    input wire logic         wb_we_i,
    input wire logic [7:0]   wb_adr_i,
    input wire logic [31:0]  wb_dat_o,
    input wire logic         wb_ack_o,
    // Signals
    input wire logic [N-1:0] sw_set,
    input wire logic [N-1:0] user_output_logic,
    input wire logic [N-1:0] user_input_signal,
    input wire logic [N-1:0] user_output_signal,
    input wire logic         irq
);
    // ==========
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_out_copy;
        !$past(sys_rst) |-> user_output_signal == $past(user_output_logic);
    endproperty
    a_out_copy: assert property (p_out_copy) else $error("output bank lost user logic");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_read_out;
        wb_ack_o && !wb_we_i && wb_adr_i == `LSB_ADDR_OUT_STATE |-> wb_dat_o == $past(user_output_signal);
    endproperty
    a_read_out: assert property (p_read_out) else $error("output state read wrong");
    property p_read_in;
        wb_ack_o && !wb_we_i && wb_adr_i == `LSB_ADDR_IN_STATE |-> wb_dat_o == $past(user_input_signal);
    endproperty
    a_read_in: assert property (p_read_in) else $error("input state read wrong");
    property p_set_in;
        |(sw_set & ~user_input_signal) |=>
            (user_input_signal & $past(sw_set & ~user_input_signal)) == $past(sw_set & ~user_input_signal);
    endproperty
    a_set_in: assert property (p_set_in) else $error("switch set not taken");
    property p_rst_zero;
        $fell(sys_rst) |-> user_input_signal == 0 && user_output_signal == 0 && !wb_ack_o;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("state kept over reset");
    property p_in_cause;
        |(user_input_signal & ~$past(user_input_signal) & ~$past(sw_set)) |->
            $past(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `LSB_ADDR_CMD_SET);
    endproperty
    a_in_cause: assert property (p_in_cause) else $error("input rose without command");
    c_irq: cover property ($rose(irq));
    c_pulse: cover property ($fell(user_input_signal[0]));
    c_read: cover property (wb_ack_o && !wb_we_i);
endmodule // lsb_bank_checker
bind lsb_bank lsb_bank_checker #(.N(N)) i_lsb_bank_checker (.clk(clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sw_set(sw_set), .user_output_logic(user_output_logic),
    .user_input_signal(user_input_signal), .user_output_signal(user_output_signal), .irq(irq));
`default_nettype wire

// ---- sim/lsb_bank_test.sv ----
// Self-checking bench for lsb_bank with a user logic model.
// Standalone; one ms is shortened to 20 clocks.
`timescale 1ns/1ps
`default_nettype none
`include "lsb_defines.vh"
module lsb_bank_test;
    localparam MS = 20;
    localparam DLY = 40;
    logic        clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, ack, irq;
    logic [7:0]  adr = 0;
    logic [7:0]  za [6] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h24, 8'h3c};
    logic [31:0] dat = 0, dat_o, sw_set = 0, sw_clr = 0, pattern = 0, ulog, uin, uout, q, t0;
    int          error_cnt = 0, n_tests = 0, n, k, e;
    lsb_bank #(.MS_CYCLES(MS)) i_lsb_bank (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .sw_set(sw_set), .sw_clr(sw_clr), .user_output_logic(ulog), .user_input_signal(uin),
        .user_output_signal(uout), .irq(irq));
    lsb_user_logic #(.DLY(DLY)) i_lsb_user_logic (.clk(clk), .user_input_signal(uin), .pattern(pattern),
        .user_output_logic(ulog));
    initial forever #25 clk = ~clk;
    // ==========
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        for (i = 0; ack !== 1'b1; i++)
        begin
            if (i == 20)
            begin
                error_cnt++;
                $display("wrong value at %0t: no acknowledge", $time);
                close_out;
            end
            @(posedge clk);
        end
        q = dat_o;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic set_pulse(input logic [31:0] m);
        sw_set <= m;
        @(posedge clk);
        sw_set <= 0;
        repeat (5) @(posedge clk);
    endtask
    // ==========
    // Sequence
    initial
    begin
        k = $urandom(22940);
        repeat (5) @(posedge clk);
        sys_rst <= 0;
        foreach (za[i])
        begin
            wb(0, za[i], 0);
            check(q, 0);
        end
        wb(1, 8'h3c, 32'hffff_ffff);
        wb(0, 8'h3c, 0);
        check(q, 0);
        $display("reset test done");
        pattern <= $urandom & 32'hffff_ffde;
        repeat (3) @(posedge clk);
        wb(0, `LSB_ADDR_OUT_STATE, 0);
        check(q, pattern & 32'hffff_fffe);
        k = 1 + $urandom % 31;
        set_pulse(32'h1 << k);
        repeat (200) @(posedge clk);
        wb(0, `LSB_ADDR_IN_STATE, 0);
        check(q, 32'h1 << k);
        wb(1, `LSB_ADDR_CMD_CLR, 32'h1 << k);
        wb(0, `LSB_ADDR_IN_STATE, 0);
        check(q, 0);
        $display("hold test done");
        wb(1, `LSB_ADDR_IN_MODE, 1);
        wb(1, `LSB_ADDR_CMD_SET, 1);
        for (n = 0; uin[0] === 1'b1 && n < 300; n++)
        begin
            @(posedge clk);
            sw_clr <= {31'h0, n == 10};
            sw_set <= {31'h0, n == 30};
        end
        check(n == 5 * MS, 1);
        repeat (10) @(posedge clk);
        check(uout[0], 1);
        repeat (DLY) @(posedge clk);
        check(uout[0], 0);
        wb(1, `LSB_ADDR_IN_MODE, 0);
        $display("pulse test done");
        for (e = 0; e < 4; e++)
        begin
            wb(1, `LSB_ADDR_EV_ENABLE, 32'h1 << e);
            if (e < 2)
                pattern[5] <= 1'b1;
            else
                set_pulse(32'h20);
            repeat (5) @(posedge clk);
            if (e < 2)
                pattern[5] <= 1'b0;
            else
                wb(1, `LSB_ADDR_CMD_CLR, 32'h20);
            repeat (5) @(posedge clk);
            wb(0, `LSB_ADDR_EV_FIFO, 0);
            check(q, 32'h8000_0005 | (e / 2) << 8 | (~e & 1) << 5);
            wb(0, `LSB_ADDR_EV_FIFO, 0);
            check(q[31], 0);
        end
        $display("event filter test done");
        wb(0, `LSB_ADDR_IRQ_STATUS, 0);
        wb(1, `LSB_ADDR_EV_ENABLE, 4);
        wb(1, `LSB_ADDR_IRQ_MASK, 1);
        wb(0, `LSB_ADDR_TIME, 0);
        t0 = q;
        set_pulse(32'h80);
        check(irq, 1);
        wb(0, `LSB_ADDR_IRQ_STATUS, 0);
        check(q, 1);
        check(irq, 0);
        wb(0, `LSB_ADDR_EV_FIFO, 0);
        check(q, 32'h8000_0127);
        wb(0, `LSB_ADDR_EV_STAMP, 0);
        check(q - t0 <= 1, 1);
        wb(1, `LSB_ADDR_IRQ_MASK, 0);
        set_pulse(32'h100);
        check(irq, 0);
        wb(0, `LSB_ADDR_IRQ_STATUS, 0);
        check(q, 1);
        $display("stamp and interrupt test done");
        sys_rst <= 1;
        repeat (5) @(posedge clk);
        sys_rst <= 0;
        wb(0, `LSB_ADDR_IN_STATE, 0);
        check(q, 0);
        $display("restart test done");
        close_out;
    end
endmodule // lsb_bank_test
`default_nettype wire
